// [rtl/estc_decoder.sv]
// Syndrome decoder of the 72/64 single-correct double-detect code.
// Purely combinational; assumes the caller registers its result.
`timescale 1ns/1ps
`default_nettype none
module estc_decoder (
    // Received word.
    input  wire logic [63:0] dataIn,
    input  wire logic [7:0]  checkIn,
    // Corrected word and outcome.
    output logic      [63:0] dataOut,
    output logic      [6:0]  syndrome,
    output logic             singleErr,
    output logic             doubleErr
);

    // Recompute the position checks, then flip the named data bit.
    always_comb begin
        int k;
        logic [6:0] pos;
        logic       parity;
        k = 0;
        pos = 7'h00;
        parity = 1'b0;
        syndrome = checkIn[6:0];
        for (int p = 1; p < 72; p++) begin
            pos = p[6:0];
            if ((pos & (pos - 7'h01)) != 7'h00) begin
                for (int i = 0; i < 7; i++) begin
                    if (pos[i]) begin
                        syndrome[i] = syndrome[i] ^ dataIn[k];
                    end
                end
                k = k + 1;
            end
        end
        parity = (^dataIn) ^ (^checkIn);
        // Odd parity means one error; even with a syndrome means two.
        singleErr = parity;
        doubleErr = !parity && (syndrome != 7'h00);
        dataOut = dataIn;
        k = 0;
        for (int p = 1; p < 72; p++) begin
            pos = p[6:0];
            if ((pos & (pos - 7'h01)) != 7'h00) begin
                if (parity && (syndrome == pos)) begin
                    dataOut[k] = !dataIn[k];
                end
                k = k + 1;
            end
        end
    end

endmodule : estc_decoder
`default_nettype wire

// [rtl/estc_encoder.sv]
// Check-bit generator of the 72/64 single-correct double-detect code.
// Purely combinational; assumes the caller registers its result.
`timescale 1ns/1ps
`default_nettype none
module estc_encoder (
    // Data word to protect.
    input  wire logic [63:0] dataIn,
    // Seven position checks and the overall parity in bit seven.
    output logic      [7:0]  checkOut
);

    // Data bits sit at the non-power-of-two positions 3 to 71.
    always_comb begin
        int k;
        logic [6:0] pos;
        k = 0;
        pos = 7'h00;
        checkOut = 8'h00;
        for (int p = 1; p < 72; p++) begin
            pos = p[6:0];
            if ((pos & (pos - 7'h01)) != 7'h00) begin
                for (int i = 0; i < 7; i++) begin
                    if (pos[i]) begin
                        checkOut[i] = checkOut[i] ^ dataIn[k];
                    end
                end
                k = k + 1;
            end
        end
        // Overall parity covers data and the seven position checks.
        checkOut[7] = (^dataIn) ^ (^checkOut[6:0]);
    end

endmodule : estc_encoder
`default_nettype wire

// [rtl/estc_pkg.sv]
// Package for the coder self-test control block: register indexes, field
// positions, reset values, the automatic test word and the state encoding.
// Assumes a word-addressed register file behind a classic Wishbone slave.
package estc_pkg;

    // Register indexes; the byte address is four times the index.
    localparam logic [9:0] IDX_CTRL     = 10'h11d; // Self-test control.
    localparam logic [9:0] IDX_IN0      = 10'h11e; // Manual input byte zero.
    localparam logic [9:0] IDX_RES0     = 10'h127; // Result byte zero.
    localparam logic [9:0] IDX_STATUS   = 10'h130; // Sticky event flags.
    localparam logic [9:0] IDX_MASK     = 10'h131; // Interrupt mask.
    localparam logic [3:0] NUM_IN_BYTES = 4'h9;    // Manual input bytes.
    localparam logic [3:0] NUM_RES      = 4'h9;    // Result bytes.

    // Control register field positions.
    localparam int CTRL_START = 0; // Test start, level, not self-clearing.
    localparam int CTRL_PATH  = 1; // One runs the encoder, zero the decoder.
    localparam int CTRL_SRC   = 2; // One takes the manual input bytes.
    localparam int CTRL_CHECK = 3; // One tests double-error detection.
    localparam int CTRL_BITS  = 4; // Writable width; upper bits read zero.

    // Status and mask field positions.
    localparam int ST_SEC  = 0; // Single-error-fixed flag.
    localparam int ST_DED  = 1; // Double-error-found flag.
    localparam int ST_DONE = 2; // Test-finished event.
    localparam int ST_BITS = 3;

    // Reset values.
    localparam logic [3:0] CTRL_RESET   = 4'h0;
    localparam logic [7:0] IN_RESET     = 8'h00;
    localparam logic [7:0] RES_RESET    = 8'h00;
    localparam logic [2:0] STATUS_RESET = 3'h0;
    localparam logic [2:0] MASK_RESET   = 3'h0;

    // Internal test word and the errors injected into it.
    localparam logic [63:0] AUTO_WORD = 64'h5a3c_96e1_0f87_c3a5;
    localparam logic [63:0] SEC_INJECT = 64'h0000_0000_0001_0000;
    localparam logic [63:0] DED_INJECT = 64'h0000_0100_0000_0002;

    // Test sequencer states, one-hot.
    typedef enum logic [2:0] {
        S_IDLE = 3'b001,
        S_RUN  = 3'b010,
        S_DONE = 3'b100
    } estc_state_e;

endpackage : estc_pkg

// [rtl/estc_top.sv]
// Coder self-test control: registers, test sequencer, sticky flags, irq.
// Assumes a classic Wishbone master on clk_sys and a free-running clock.
// Behaviour
// RULE_01 Start bit set launches test; zero idles.
// RULE_02 Start bit never self-clears; software drops it.
// RULE_03 Path select: zero decoder, one encoder.
// RULE_04 Source zero uses internal data; else inputs.
// RULE_05 Manual encoder test feeds input bytes 0-7.
// RULE_06 Manual decoder test feeds input bytes 0-8.
// RULE_07 Software reads result bytes after a test.
// RULE_08 Check select ignored for manual or encoder.
// RULE_09 Check zero tests correction, sets single flag.
// RULE_10 Correction test stores corrected word as results.
// RULE_11 Check one sets double flag; results ignored.
// RULE_12 Control bits 7-4 read zero; 3-0 writable.
// RULE_13 Input bytes consecutive, eight-bit, reset zero.
// RULE_14 Error flags stay set until cleared.
// RULE_15 Internal word carries a known injected error.
`timescale 1ns/1ps
`default_nettype none
module estc_top
    import estc_pkg::*;
(
    // Clock, reset and clock enable.
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    input  wire logic        clkEn,
    // Classic Wishbone slave.
    input  wire logic        wbCyc,
    input  wire logic        wbStb,
    input  wire logic        wbWe,
    input  wire logic [11:0] wbAdr,
    input  wire logic [3:0]  wbSel,
    input  wire logic [31:0] wbDatIn,
    output logic      [31:0] wbDatOut,
    output logic             wbAck,
    // Status towards the system.
    output logic             testActive,
    output logic             irq
);

    // Register state.
    logic [3:0]  ctrlQ, ctrlD;                 // Control bits 3 to 0.
    logic [7:0]  inByteQ [0:8];                // Manual input bytes.
    logic [7:0]  inByteD [0:8];
    logic [7:0]  resQ [0:8];                   // Result bytes.
    logic [7:0]  resD [0:8];
    logic [2:0]  statusQ, statusD;             // Sticky flags.
    logic [2:0]  maskQ, maskD;                 // Interrupt mask.
    logic        ackQ, ackD;                   // Bus answer.
    logic [31:0] rdatQ, rdatD;                 // Read data.
    estc_state_e stateQ, stateD;               // Test sequencer.

    // Bus decode.
    logic        busReq;                       // A request is on the bus.
    logic        wrTake;                       // Write at the acked edge.
    logic [9:0]  idx;                          // Word index.
    logic [9:0]  inOff;                        // Index within input bytes.
    logic [9:0]  resOff;                       // Index within result bytes.
    logic        hitIn;                        // Input byte addressed.
    logic        hitRes;                       // Result byte addressed.

    // Coder datapath.
    logic [63:0] manualWord;                   // Input bytes 0 to 7.
    logic [63:0] encIn;                        // Word into the encoder.
    logic [7:0]  encCheck;                     // Encoder check byte.
    logic [63:0] decData;                      // Word into the decoder.
    logic [7:0]  decCheck;                     // Check into the decoder.
    logic [63:0] decOut;                       // Corrected word.
    logic [6:0]  decSyn;                       // Decoder syndrome.
    logic        decSingle;                    // Single error seen.
    logic        decDouble;                    // Double error seen.
    logic        pathEnc;                      // Encoder test chosen.
    logic        srcManual;                    // Manual source chosen.

    assign busReq = wbCyc && wbStb;
    assign wrTake = busReq && ackQ && wbWe && wbSel[0];
    assign idx    = wbAdr[11:2];
    assign inOff  = idx - IDX_IN0;
    assign resOff = idx - IDX_RES0;
    assign hitIn  = (idx >= IDX_IN0) && (inOff < {6'h00, NUM_IN_BYTES}); // RULE_13
    assign hitRes = (idx >= IDX_RES0) && (resOff < {6'h00, NUM_RES});
    assign pathEnc   = ctrlQ[CTRL_PATH];
    assign srcManual = ctrlQ[CTRL_SRC];

    // Gather input bytes 0 to 7 into one word, byte zero lowest.
    always_comb begin
        manualWord = 64'h0;
        for (int b = 0; b < 8; b++) begin
            manualWord[b*8 +: 8] = inByteQ[b];
        end
    end

    // Encoder input: manual bytes or the internal word.
    assign encIn = srcManual ? manualWord : AUTO_WORD; // RULE_04 RULE_05

    // Decoder input: nine manual bytes, or the encoded internal word with an
    // injected error; the check select matters only on the latter path.
    always_comb begin
        if (srcManual) begin
            decData  = manualWord; // RULE_06
            decCheck = inByteQ[8];
        end else if (ctrlQ[CTRL_CHECK]) begin
            decData  = AUTO_WORD ^ DED_INJECT; // RULE_15 RULE_08
            decCheck = encCheck;
        end else begin
            decData  = AUTO_WORD ^ SEC_INJECT; // RULE_15
            decCheck = encCheck;
        end
    end

    // Shared check-bit generator.
    estc_encoder uEnc (
        .dataIn   (encIn),
        .checkOut (encCheck)
    );

    // Syndrome decoder under test.
    estc_decoder uDec (
        .dataIn    (decData),
        .checkIn   (decCheck),
        .dataOut   (decOut),
        .syndrome  (decSyn),
        .singleErr (decSingle),
        .doubleErr (decDouble)
    );

    // Sequencer: one run cycle per start, then wait for the start to drop.
    always_comb begin
        stateD = stateQ;
        unique case (stateQ)
            S_IDLE: begin
                // A set start bit launches the configured test.
                if (ctrlQ[CTRL_START]) begin
                    stateD = S_RUN; // RULE_01
                end
            end
            S_RUN: begin
                stateD = S_DONE;
            end
            S_DONE: begin
                // Only software dropping the bit returns to normal.
                if (!ctrlQ[CTRL_START]) begin
                    stateD = S_IDLE; // RULE_02
                end
            end
            default: begin
                stateD = S_IDLE;
            end
        endcase
    end

    // Register writes, result capture and sticky flags.
    always_comb begin
        ctrlD   = ctrlQ;
        maskD   = maskQ;
        statusD = statusQ;
        for (int b = 0; b < 9; b++) begin
            inByteD[b] = inByteQ[b];
            resD[b]    = resQ[b];
        end
        // Writes land at the edge where the master samples ack.
        if (wrTake) begin
            if (idx == IDX_CTRL) begin
                ctrlD = wbDatIn[CTRL_BITS-1:0]; // RULE_12 RULE_02
            end
            if (idx == IDX_MASK) begin
                maskD = wbDatIn[ST_BITS-1:0];
            end
            if (hitIn) begin
                inByteD[inOff[3:0]] = wbDatIn[7:0]; // RULE_13
            end
            // Writing a one clears a status bit.
            if (idx == IDX_STATUS) begin
                statusD = statusQ & ~wbDatIn[ST_BITS-1:0]; // RULE_14
            end
        end
        // Test outcome; a set in the clearing cycle wins.
        if (stateQ == S_RUN) begin
            statusD[ST_DONE] = 1'b1;
            if (pathEnc) begin
                for (int b = 0; b < 8; b++) begin
                    resD[b] = encIn[b*8 +: 8]; // RULE_03
                end
                resD[8] = encCheck;
            end else begin
                for (int b = 0; b < 8; b++) begin
                    resD[b] = decOut[b*8 +: 8]; // RULE_10
                end
                resD[8] = {1'b0, decSyn};
                if (decSingle) begin
                    statusD[ST_SEC] = 1'b1; // RULE_09
                end
                if (decDouble) begin
                    statusD[ST_DED] = 1'b1; // RULE_11
                end
            end
        end
    end

    // Bus answer: ack one cycle after the request, dropped the cycle after.
    always_comb begin
        ackD  = busReq && !ackQ;
        rdatD = rdatQ;
        if (busReq && !ackQ) begin
            rdatD = 32'h0;
            if (idx == IDX_CTRL) begin
                rdatD = {28'h0, ctrlQ}; // RULE_12
            end else if (idx == IDX_STATUS) begin
                rdatD = {29'h0, statusQ};
            end else if (idx == IDX_MASK) begin
                rdatD = {29'h0, maskQ};
            end else if (hitIn) begin
                rdatD = {24'h0, inByteQ[inOff[3:0]]};
            end else if (hitRes) begin
                rdatD = {24'h0, resQ[resOff[3:0]]}; // RULE_07
            end
        end
    end

    // State registers; the clock enable freezes everything.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ctrlQ   <= CTRL_RESET;
            maskQ   <= MASK_RESET;
            statusQ <= STATUS_RESET;
            ackQ    <= 1'b0;
            rdatQ   <= 32'h0;
            stateQ  <= S_IDLE;
            for (int b = 0; b < 9; b++) begin
                inByteQ[b] <= IN_RESET;
                resQ[b]    <= RES_RESET;
            end
        end else if (clkEn) begin
            ctrlQ   <= ctrlD;
            maskQ   <= maskD;
            statusQ <= statusD;
            ackQ    <= ackD;
            rdatQ   <= rdatD;
            stateQ  <= stateD;
            for (int b = 0; b < 9; b++) begin
                inByteQ[b] <= inByteD[b];
                resQ[b]    <= resD[b];
            end
        end
    end

    // Outputs.
    assign wbAck      = ackQ;
    assign wbDatOut   = rdatQ;
    // High from launch until start drops.
    assign testActive = (stateQ != S_IDLE);
    // Level request of unmasked flags.
    assign irq        = |(statusQ & maskQ);

    // Checks on the sequencer, flags and bus.
    a_start_runs: assert property (@(posedge clk_sys) // RULE_01
        disable iff (!reset_n)
        (stateQ == S_IDLE && ctrlQ[CTRL_START] && clkEn) |=> stateQ == S_RUN)
        else $error("start did not launch a test");
    a_idle_no_test: assert property (@(posedge clk_sys) // RULE_01
        disable iff (!reset_n)
        (!ctrlQ[CTRL_START] && stateQ != S_RUN && clkEn) |=> !testActive)
        else $error("test active with start low");
    a_start_sticky: assert property (@(posedge clk_sys) // RULE_02
        disable iff (!reset_n)
        (ctrlQ[CTRL_START] && !wrTake && clkEn) |=> ctrlQ[CTRL_START])
        else $error("start bit cleared itself");
    a_enc_result: assert property (@(posedge clk_sys) // RULE_03
        disable iff (!reset_n)
        (stateQ == S_RUN && pathEnc && clkEn) |=>
        {resQ[7], resQ[0]} == {$past(encIn[63:56]), $past(encIn[7:0])})
        else $error("encoder result not stored");
    a_auto_sec: assert property (@(posedge clk_sys) // RULE_09
        disable iff (!reset_n)
        (stateQ == S_RUN && !pathEnc && !srcManual && !ctrlQ[CTRL_CHECK]
         && clkEn) |=> statusQ[ST_SEC] && !$past(statusQ[ST_DED]) ==
         !statusQ[ST_DED] && {resQ[2], resQ[1]} == AUTO_WORD[23:8])
        else $error("correction test outcome wrong");
    a_auto_ded: assert property (@(posedge clk_sys) // RULE_11
        disable iff (!reset_n)
        (stateQ == S_RUN && !pathEnc && !srcManual && ctrlQ[CTRL_CHECK]
         && clkEn) |=> statusQ[ST_DED])
        else $error("double error not flagged");
    a_flag_hold: assert property (@(posedge clk_sys) // RULE_14
        disable iff (!reset_n)
        (statusQ[ST_SEC] && !(wrTake && idx == IDX_STATUS) && clkEn)
        |=> statusQ[ST_SEC])
        else $error("single flag lost");
    a_ctrl_rsvd: assert property (@(posedge clk_sys) // RULE_12
        disable iff (!reset_n)
        (ackQ && idx == IDX_CTRL && busReq) |-> wbDatOut[31:4] == 28'h0)
        else $error("reserved control bits not zero");
    a_ack_pulse: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (busReq && !ackQ && clkEn) |=> ackQ ##1 !ackQ [*1])
        else $error("ack not a single cycle");
    a_irq_level: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (stateQ == S_RUN && maskQ[ST_DONE] && !wrTake && clkEn) |=> irq)
        else $error("interrupt does not follow flags");

    // Further checks.
    a_ded_hold: assert property (@(posedge clk_sys) // RULE_14
        disable iff (!reset_n)
        (statusQ[ST_DED] && !(wrTake && idx == IDX_STATUS) && clkEn)
        |=> statusQ[ST_DED])
        else $error("double flag lost");

    a_run_done: assert property (@(posedge clk_sys) // RULE_01
        disable iff (!reset_n)
        (stateQ == S_RUN && clkEn) |=> stateQ == S_DONE && statusQ[ST_DONE])
        else $error("run did not finish");

    a_res_stable: assert property (@(posedge clk_sys) // RULE_10
        disable iff (!reset_n)
        (stateQ != S_RUN && clkEn) |=> $stable(resQ[0]) && $stable(resQ[8]))
        else $error("results changed outside a run");

    a_freeze: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !clkEn |=> $stable(stateQ) && $stable(ctrlQ) && $stable(statusQ))
        else $error("state moved with enable low");

    a_enc_manual: assert property (@(posedge clk_sys) // RULE_05
        disable iff (!reset_n)
        (stateQ == S_RUN && pathEnc && srcManual && clkEn) |=>
        {resQ[7], resQ[0]} == {$past(inByteQ[7]), $past(inByteQ[0])})
        else $error("manual bytes not encoded");

    a_dec_manual: assert property (@(posedge clk_sys) // RULE_06
        disable iff (!reset_n)
        (stateQ == S_RUN && !pathEnc && srcManual && !decSingle && clkEn)
        |=> {resQ[7], resQ[0]} == {$past(inByteQ[7]), $past(inByteQ[0])})
        else $error("manual bytes not decoded");

    a_in_write: assert property (@(posedge clk_sys) // RULE_13
        disable iff (!reset_n)
        (wrTake && idx == IDX_IN0 && clkEn)
        |=> inByteQ[0] == $past(wbDatIn[7:0]))
        else $error("input byte not stored");

    // Main scenarios.
    c_enc_test: cover property (@(posedge clk_sys) disable iff (!reset_n)
        stateQ == S_RUN && pathEnc);
    c_sec_test: cover property (@(posedge clk_sys) disable iff (!reset_n)
        stateQ == S_RUN && !pathEnc && decSingle);
    c_ded_test: cover property (@(posedge clk_sys) disable iff (!reset_n)
        stateQ == S_RUN && !pathEnc && decDouble);
    c_irq_raise: cover property (@(posedge clk_sys) disable iff (!reset_n)
        $rose(irq));
    c_frozen: cover property (@(posedge clk_sys) disable iff (!reset_n)
        !clkEn && ctrlQ[CTRL_START] && stateQ == S_IDLE);

endmodule : estc_top
`default_nettype wire

// [test/estc_top_tb.sv]
// Self-checking bench for the coder self-test control block.
// Assumes estc_pkg and the design files are compiled first; one clock.
`timescale 1ns/1ps
`default_nettype none
module estc_top_tb;
    import estc_pkg::*;

    // One ordinary case: config, manual inputs and expected outcome.
    typedef struct packed {
        logic [7:0]  ctrl;
        logic [63:0] inWord;
        logic [7:0]  in8;
        logic [2:0]  expSt;
        logic        cmpRes;
        logic [63:0] expWord;
        logic [7:0]  expB8;
    } estc_row_s;

    logic        clk_sys;  // System clock, 50 ns.
    logic        reset_n;  // Asynchronous reset, active low.
    logic        clkEn;    // Clock enable, high except in the clock enable test.
    logic        wbCyc;    // Bus cycle.
    logic        wbStb;    // Bus strobe.
    logic        wbWe;     // Write when high.
    logic [11:0] wbAdr;    // Byte address.
    logic [3:0]  wbSel;    // Byte lanes.
    logic [31:0] wbDatIn;  // Write data.
    logic [31:0] wbDatOut; // Read data.
    logic        wbAck;    // Bus acknowledge.
    logic        testActive; // Test running or finished.
    logic        irq;      // Level interrupt.
    logic [31:0] rdData;   // Last value read over the bus.
    int          errCount; // Mismatches seen.
    int          nTests;   // Comparisons made.
    estc_row_s   rows[7];  // Ordinary cases.
    logic [63:0] w1;       // Manual test word.
    int          k;        // Loop index.

    // Device under test.
    estc_top dut (.clk_sys(clk_sys), .reset_n(reset_n), .clkEn(clkEn),
        .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr),
        .wbSel(wbSel), .wbDatIn(wbDatIn), .wbDatOut(wbDatOut),
        .wbAck(wbAck), .testActive(testActive), .irq(irq));

    // Clock generator.
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    // Check bits of the 72/64 code, worked out independently here.
    function automatic logic [7:0] ham(input logic [63:0] w);
        logic [7:0] c;
        int         p;
        int         j;
        c = 8'h00;
        p = 3;
        for (j = 0; j < 64; j++) begin
            while ((p & (p - 1)) == 0) p++;
            if (w[j]) c[6:0] ^= p[6:0];
            p++;
        end
        c[7] = ^{w, c[6:0]};
        return c;
    endfunction : ham

    // Compares a value seen with the value expected and counts it.
    task automatic chk(input string nm, input logic [63:0] seen,
                       input logic [63:0] exp);
        nTests++;
        if (seen !== exp) begin
            errCount++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // One classic Wishbone cycle; waits for ack under a bound.
    task automatic wb(input logic we, input logic [9:0] idx,
                      input logic [7:0] d, input logic [3:0] sel);
        int n;
        n = 0;
        @(posedge clk_sys);
        wbCyc   <= 1'b1;
        wbStb   <= 1'b1;
        wbWe    <= we;
        wbAdr   <= {idx, 2'b00};
        wbSel   <= sel;
        wbDatIn <= {24'h000000, d};
        do begin
            @(posedge clk_sys);
            n++;
        end while (wbAck !== 1'b1 && n < 50);
        if (n >= 50) begin
            errCount++;
            $display("MISMATCH ack expected 1 seen timeout");
        end
        rdData = wbDatOut;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
    endtask : wb

    // Register write and read shorthands.
    task automatic wr(input logic [9:0] idx, input logic [7:0] d);
        wb(1'b1, idx, d, 4'hf);
    endtask : wr

    task automatic rd(input logic [9:0] idx);
        wb(1'b0, idx, 8'h00, 4'hf);
    endtask : rd

    // Runs one ordinary case from launch to clean return to idle.
    task automatic run_row(input estc_row_s r);
        int j;
        for (j = 0; j < 8; j++) wr(10'(IDX_IN0 + j), r.inWord[8*j +: 8]);
        wr(10'(IDX_IN0 + 8), r.in8);
        wr(IDX_CTRL, r.ctrl);
        repeat (3) @(posedge clk_sys);
        chk("active", testActive, 1);
        rd(IDX_STATUS);
        chk("status", rdData, r.expSt);
        rd(IDX_CTRL);
        chk("ctrl", rdData, r.ctrl);
        if (r.cmpRes) begin
            for (j = 0; j < 8; j++) begin
                rd(10'(IDX_RES0 + j));
                chk("result", rdData, r.expWord[8*j +: 8]);
            end
            rd(10'(IDX_RES0 + 8));
            chk("result8", rdData, r.expB8);
        end
        wr(IDX_CTRL, r.ctrl & 8'hfe);
        repeat (2) @(posedge clk_sys);
        chk("idle", testActive, 0);
        wr(IDX_STATUS, 8'h07);
        rd(IDX_STATUS);
        chk("cleared", rdData, 0);
        $display("case ctrl %h done", r.ctrl);
    endtask : run_row

    // Prints the counts and the verdict, then ends the run.
    task automatic wrapUp();
        $display("comparisons %0d mismatches %0d", nTests, errCount);
        if (errCount == 0 && nTests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : wrapUp

    // Watchdog: the whole run needs under a thousand cycles.
    initial begin
        repeat (20000) @(posedge clk_sys);
        errCount++;
        $display("MISMATCH watchdog expected finish seen timeout");
        wrapUp();
    end

    // Main sequence.
    initial begin
        errCount = 0;
        nTests   = 0;
        reset_n  = 1'b0;
        clkEn    = 1'b1;
        wbCyc    = 1'b0;
        wbStb    = 1'b0;
        wbWe     = 1'b0;
        wbAdr    = 12'h000;
        wbSel    = 4'h0;
        wbDatIn  = 32'h00000000;
        w1       = 64'h0123_4567_89ab_cdef;
        // Auto decoder cases carry an injected fault; manual ones use w1.
        rows[0] = '{8'h01, 0, 0, 3'h5, 1, AUTO_WORD, 8'h16};
        rows[1] = '{8'h09, 0, 0, 3'h6, 0, 0, 0};
        rows[2] = '{8'h03, 0, 0, 3'h4, 1, AUTO_WORD, ham(AUTO_WORD)};
        rows[3] = '{8'h0b, 0, 0, 3'h4, 1, AUTO_WORD, ham(AUTO_WORD)};
        rows[4] = '{8'h07, w1, 8'ha5, 3'h4, 1, w1, ham(w1)};
        rows[5] = '{8'h05, w1, ham(w1), 3'h4, 1, w1, 8'h00};
        rows[6] = '{8'h0d, w1 ^ 64'h20, ham(w1), 3'h5, 1, w1, 8'h0a};
        repeat (16) @(posedge clk_sys);
        reset_n <= 1'b1;
        foreach (rows[i]) run_row(rows[i]);

        // Reserved bits, ignored lane and unmapped place.
        wr(IDX_CTRL, 8'hf0);
        rd(IDX_CTRL);
        chk("reserved", rdData, 0);
        wb(1'b1, IDX_CTRL, 8'h0e, 4'h0);
        rd(IDX_CTRL);
        chk("no lane", rdData, 0);
        wr(10'h3ff, 8'hff);
        rd(10'h3ff);
        chk("unmapped", rdData, 0);
        $display("register access test done");

        // Config change while finished has no effect; flags stay set.
        wr(IDX_CTRL, 8'h01);
        repeat (3) @(posedge clk_sys);
        wr(IDX_CTRL, 8'h09);
        repeat (3) @(posedge clk_sys);
        rd(IDX_STATUS);
        chk("held", rdData, 5);
        wr(IDX_CTRL, 8'h08);
        wr(IDX_CTRL, 8'h09);
        repeat (3) @(posedge clk_sys);
        rd(IDX_STATUS);
        chk("sticky", rdData, 7);
        wr(IDX_CTRL, 8'h00);
        wr(IDX_STATUS, 8'h07);
        $display("restart test done");

        // Interrupt raised, masked and cleared.
        wr(IDX_MASK, 8'h04);
        wr(IDX_CTRL, 8'h01);
        repeat (3) @(posedge clk_sys);
        chk("irq on", irq, 1);
        wr(IDX_MASK, 8'h00);
        repeat (2) @(posedge clk_sys);
        chk("irq masked", irq, 0);
        wr(IDX_MASK, 8'h01);
        repeat (2) @(posedge clk_sys);
        chk("irq sec", irq, 1);
        wr(IDX_STATUS, 8'h01);
        repeat (2) @(posedge clk_sys);
        chk("irq clear", irq, 0);
        $display("interrupt test done");

        // Enable low holds a launched test back.
        wr(IDX_CTRL, 8'h00);
        wr(IDX_CTRL, 8'h01);
        clkEn <= 1'b0;
        repeat (4) @(posedge clk_sys);
        chk("frozen", testActive, 0);
        clkEn <= 1'b1;
        repeat (3) @(posedge clk_sys);
        chk("thawed", testActive, 1);
        $display("clock enable test done");

        // Input bytes read back, then a reset while a finished test is still active.
        for (k = 0; k < 9; k++) wr(10'(IDX_IN0 + k), 8'(8'h11 * (k + 1)));
        for (k = 0; k < 9; k++) begin
            rd(10'(IDX_IN0 + k));
            chk("input", rdData, 8'(8'h11 * (k + 1)));
        end
        wr(IDX_MASK, 8'h04);
        repeat (3) @(posedge clk_sys);
        reset_n <= 1'b0;
        repeat (3) @(posedge clk_sys);
        chk("rst active", testActive, 0);
        chk("rst irq", irq, 0);
        reset_n <= 1'b1;
        for (k = 0; k < 9; k++) begin
            rd(10'(IDX_IN0 + k));
            chk("input rst", rdData, 0);
        end
        rd(IDX_CTRL);
        chk("ctrl rst", rdData, 0);
        rd(IDX_STATUS);
        chk("status rst", rdData, 0);
        rd(IDX_MASK);
        chk("mask rst", rdData, 0);
        $display("reset test done");
        wrapUp();
    end

endmodule : estc_top_tb
`default_nettype wire
